// ===== qdsul_top.sv
// Serial receiver, channel registers and APB slave of the quad DAC
`timescale 1ns/1ns
module qdsul_top import qdsul_pkg::*; (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_sync_b,
    input wire logic i_sclk,
    input wire logic i_sdin,
    input wire logic [7:0] i_paddr,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    output logic [CODE_BITS-1:0] o_code_a,
    output logic [CODE_BITS-1:0] o_code_b,
    output logic [CODE_BITS-1:0] o_code_c,
    output logic [CODE_BITS-1:0] o_code_d,
    output logic [3:0] o_pwr_dn,
    output logic [7:0] o_term_sel
);
    // Whole block state
    typedef struct packed {
        qdsul_state_t st; // Receiver state
        logic [WORD_BITS-1:0] shift; // Input shift register
        logic [4:0] cnt; // Bits taken this frame
        logic sclk_prev; // Last sampled link clock
        logic [3:0][CODE_BITS-1:0] inp; // Input registers
        logic [3:0][CODE_BITS-1:0] dac; // DAC registers
        logic [3:0] pd; // Powered-down channels
        logic [3:0][1:0] term; // Termination per channel
        logic link_en; // Software link enable
        logic [WORD_BITS-1:0] last; // Last complete word
        logic [7:0] good_cnt; // Completed frames
        logic [7:0] abort_cnt; // Aborted frames
        logic [WORD_BITS-1:0] soft_word; // Pending software word
        logic soft_pend; // Software word waiting
        logic [31:0] prdata; // Read data
        logic slverr; // Error answer
    } qdsul_regs_t;

    qdsul_regs_t r_q, r_d;
    logic [1:0] rst_pipe_q; // Reset release pipe
    logic rst_n; // Synchronised reset
    logic [2:0] pins_s; // Synchronised link pins
    logic sync_s; // Frame select, high is idle
    logic sclk_s; // Link clock
    logic sdin_s; // Link data
    logic fall; // Falling link clock seen
    logic link_apply; // Sixteenth bit arrived
    logic soft_apply; // Software word applies now
    logic [WORD_BITS-1:0] new_word; // Word just completed
    logic [WORD_BITS-1:0] cmd_word; // Word to decode
    logic [CODE_BITS-1:0] cmd_code; // Its code field
    logic [3:0] wr_inp; // Input write mask
    logic [3:0] wr_dac; // DAC write mask
    logic [3:0] cp_dac; // DAC copy mask
    logic [3:0] pd_set; // Power-down mask
    logic [1:0] term_new; // Requested termination
    logic setup_ph; // APB setup cycle
    logic wr_acc; // APB write access
    logic [7:0] rd_idx; // Channel offset within bank

    // Release reset through two flops
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rst_pipe_q <= 2'b00;
        end else begin
            rst_pipe_q <= {rst_pipe_q[0], 1'b1};
        end
    end
    assign rst_n = rst_pipe_q[1];

    // Pins come from the host's clock domain
    qdsul_sync2 #(
        .W(3),
        .RST_VAL(3'b101)
    ) u_pin_sync (
        .i_clk(i_clk),
        .i_rst_b(rst_n),
        .i_d({i_sync_b, i_sclk, i_sdin}),
        .o_q(pins_s)
    );
    assign sync_s = pins_s[2];
    assign sclk_s = pins_s[1];
    assign sdin_s = pins_s[0];

    // Link clock edge and frame completion
    always_comb begin
        fall = r_q.sclk_prev & ~sclk_s;
        new_word = {r_q.shift[WORD_BITS-2:0], sdin_s};
        link_apply = (r_q.st == ST_SHIFT) && !sync_s && fall
            && (r_q.cnt == LAST_BIT);
        soft_apply = r_q.soft_pend && !link_apply;
        cmd_word = link_apply ? new_word : r_q.soft_word;
        cmd_code = cmd_word[CODE_BITS-1:0];
    end

    // Word to register masks
    qdsul_decode u_decode (
        .i_word(cmd_word),
        .o_wr_inp(wr_inp),
        .o_wr_dac(wr_dac),
        .o_cp_dac(cp_dac),
        .o_pd_set(pd_set),
        .o_term(term_new)
    );

    // APB phase decode
    always_comb begin
        setup_ph = i_psel && !i_penable;
        wr_acc = i_psel && i_penable && i_pwrite && !r_q.slverr;
        rd_idx = {4'h0, i_paddr[3:0]};
    end

    // Next state of the whole block
    always_comb begin
        r_d = r_q;
        r_d.sclk_prev = sclk_s;
        // Serial receiver
        unique case (r_q.st)
            ST_IDLE: begin
                r_d.cnt = 5'h00;
                if (!sync_s && r_q.link_en) begin
                    r_d.st = ST_SHIFT;
                end
            end
            ST_SHIFT: begin
                if (sync_s) begin
                    r_d.st = ST_IDLE;
                    r_d.abort_cnt = r_q.abort_cnt + 8'h01;
                end else if (fall) begin
                    r_d.shift = new_word;
                    r_d.cnt = r_q.cnt + 5'h01;
                    if (link_apply) begin
                        r_d.st = ST_DONE;
                        r_d.last = new_word;
                        r_d.good_cnt = r_q.good_cnt + 8'h01;
                    end
                end
            end
            ST_DONE: begin
                // Extra clocks and data are dropped here
                if (sync_s) begin
                    r_d.st = ST_IDLE;
                    // Counter restarts as soon as the frame closes
                    r_d.cnt = 5'h00;
                end
            end
            default: begin
                r_d.st = ST_IDLE;
            end
        endcase
        // Apply a complete word to the channels
        if (link_apply || soft_apply) begin
            for (int i = 0; i < NUM_CH; i++) begin
                if (wr_inp[i]) begin
                    r_d.inp[i] = cmd_code;
                end
                if (wr_dac[i]) begin
                    r_d.dac[i] = cmd_code;
                end else if (cp_dac[i]) begin
                    r_d.dac[i] = r_q.inp[i];
                end
                if (wr_dac[i] || cp_dac[i]) begin
                    r_d.pd[i] = 1'b0;
                end
                if (pd_set[i]) begin
                    r_d.pd[i] = 1'b1;
                    r_d.term[i] = term_new;
                end
            end
        end
        if (soft_apply) begin
            r_d.soft_pend = 1'b0;
        end
        // APB setup: fetch read data, flag holes
        if (setup_ph) begin
            r_d.slverr = 1'b0;
            r_d.prdata = 32'h0000_0000;
            if (i_paddr == OFS_CTRL) begin
                r_d.prdata = {31'h0000_0000, r_q.link_en};
            end else if (i_paddr == OFS_STATUS) begin
                r_d.prdata = {8'h00, r_q.abort_cnt, r_q.good_cnt,
                    1'b0, r_q.cnt, r_q.st};
            end else if (i_paddr == OFS_LAST) begin
                r_d.prdata = {16'h0000, r_q.last};
            end else if (i_paddr == OFS_SOFT) begin
                r_d.prdata = {15'h0000, r_q.soft_pend, r_q.soft_word};
            end else if (i_paddr == OFS_PWR) begin
                r_d.prdata = {20'h00000, r_q.term, r_q.pd};
            end else if (i_paddr[7:4] == OFS_INP0[7:4]
                && rd_idx[1:0] == 2'h0) begin
                r_d.prdata = {20'h00000, r_q.inp[rd_idx[3:2]]};
            end else if (i_paddr[7:4] == OFS_DAC0[7:4]
                && rd_idx[1:0] == 2'h0) begin
                r_d.prdata = {20'h00000, r_q.dac[rd_idx[3:2]]};
            end else begin
                r_d.slverr = 1'b1;
            end
        end
        // APB access: writes take effect, set wins over clear
        if (wr_acc) begin
            if (i_paddr == OFS_CTRL) begin
                r_d.link_en = i_pwdata[0];
            end else if (i_paddr == OFS_SOFT) begin
                r_d.soft_word = i_pwdata[WORD_BITS-1:0];
                r_d.soft_pend = 1'b1;
            end
        end
    end

    // Register the state; reset gives zero scale
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            r_q <= '0;
            r_q.st <= ST_IDLE;
            // Matches the parked-low clock, so no false fall
            r_q.sclk_prev <= 1'b0;
            r_q.link_en <= CTRL_EN_RST;
            r_q.inp <= {NUM_CH{CODE_RST}};
            r_q.dac <= {NUM_CH{CODE_RST}};
        end else begin
            r_q <= r_d;
        end
    end

    // Outputs
    assign o_pready = 1'b1;
    assign o_prdata = r_q.prdata;
    assign o_pslverr = r_q.slverr && i_psel && i_penable;
    assign o_code_a = r_q.dac[0];
    assign o_code_b = r_q.dac[1];
    assign o_code_c = r_q.dac[2];
    assign o_code_d = r_q.dac[3];
    assign o_pwr_dn = r_q.pd;
    assign o_term_sel = r_q.term;

    // Checks on the design's own behaviour
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!rst_n);

    // Bit counter never passes sixteen
    a_cnt_bounded: assert property (
        r_q.cnt <= 5'h10
    ) else $error("bit counter passed sixteen");

    // Early rise of select keeps input registers
    a_abort_keeps_inp: assert property (
        (r_q.st == ST_SHIFT && sync_s && !r_q.soft_pend)
        |=> $stable(r_q.inp) && r_q.st == ST_IDLE
    ) else $error("aborted frame changed registers");

    // Idle select takes no bits
    a_no_bits_idle: assert property (
        sync_s && r_q.st != ST_SHIFT |=> r_q.cnt == 5'h00
            || r_q.st == ST_DONE
    ) else $error("bits taken while select high");

    // After sixteen bits the shift register holds
    a_done_holds: assert property (
        r_q.st == ST_DONE |=> $stable(r_q.shift)
    ) else $error("bits taken after sixteenth edge");

    // Done waits for select high before idle
    a_done_waits: assert property (
        r_q.st == ST_DONE && !sync_s |=> r_q.st == ST_DONE
    ) else $error("new frame without select cycling");

    // Store only leaves DAC outputs alone
    a_store_only: assert property (
        link_apply && new_word[15:14] == 2'b00
        |=> $stable(r_q.dac)
    ) else $error("store command moved a DAC register");

    // Load both shows the code one cycle later
    a_load_both: assert property (
        link_apply && new_word[15:12] == 4'b1000
        |=> o_code_a == $past(new_word[11:0]) && !o_pwr_dn[0]
    ) else $error("load both did not reach channel A");

    // Broadcast update sets all four equal
    a_all_update: assert property (
        link_apply && new_word[15:12] == 4'b1100
        |=> o_code_a == o_code_b && o_code_c == o_code_d
            && o_code_a == o_code_c
    ) else $error("broadcast update missed a channel");

    // Power-down of all channels
    a_pd_all: assert property (
        link_apply && new_word[15:11] == 5'b11111
        |=> o_pwr_dn == 4'hF
    ) else $error("all-channel power down missed");

    // Sixteen falls complete the frame
    a_frame_len: assert property (
        link_apply |-> r_q.cnt == LAST_BIT ##1 r_q.st == ST_DONE
    ) else $error("frame completed at wrong count");

    // Copy moves channel B input register into its DAC
    a_copy_to_dac: assert property (
        link_apply && new_word[15:12] == 4'b0101
        |=> o_code_b == $past(r_q.inp[1])
    ) else $error("copy command missed channel B");

    // Store writes the input register of channel C
    a_store_inp: assert property (
        link_apply && new_word[15:12] == 4'b0010
        |=> r_q.inp[2] == $past(new_word[11:0])
    ) else $error("store missed channel C input register");

    // Each aborted frame is counted once
    a_abort_count: assert property (
        r_q.st == ST_SHIFT && sync_s
        |=> r_q.abort_cnt == $past(r_q.abort_cnt) + 8'h01
    ) else $error("aborted frame not counted");

    // Single-channel power-down of channel B
    a_pd_one: assert property (
        link_apply && new_word[15:9] == 7'b1111001
        |=> o_pwr_dn[1]
    ) else $error("channel B power down missed");

    // Termination code three shows as high impedance
    a_term_hiz: assert property (
        link_apply && new_word[15:7] == 9'b111101111
        |=> o_term_sel[7:6] == TERM_HIZ
    ) else $error("termination code three not high impedance");

    // Disabled link never starts a frame
    a_link_off: assert property (
        !r_q.link_en && r_q.st == ST_IDLE |=> r_q.st == ST_IDLE
    ) else $error("frame started with link disabled");

    // Main scenarios
    c_frame_done: cover property (link_apply);
    c_frame_abort: cover property (
        r_q.st == ST_SHIFT && sync_s && r_q.cnt != 5'h00);
    c_power_down: cover property (|pd_set && link_apply);
    c_soft_cmd: cover property (soft_apply);
    c_surplus_bits: cover property (r_q.st == ST_DONE && fall);
endmodule // qdsul_top

// ===== qdsul_pkg.sv
// Constants, types and helpers for the quad DAC serial update logic
// Operation
// - Frame is 16 bits: control then code
// - Bits shift in MSB first, bit 15 leads
// - Load bits pick input, DAC or both
// - Bits 13:12 pick channel or all
// - Load bits 11 update all four channels, except single-channel power-down (bit 11 low)
// - Code is straight unsigned binary, zero is zero
// - Codes 0 to 4095 pass unchanged
// - Frame select low enables bit capture
// - One bit per falling clock, sixteen bits
// - Bits after the sixteenth are ignored
// - New word needs select high then low
// - Full word moves into selected register
// - Early select rise aborts, registers kept
// - Reset clears registers to zero scale
// - Single or all channel power down
// - Load codes: store, copy, both, special
// - All control ones means power-down command
package qdsul_pkg;
    // Link word geometry
    localparam int WORD_BITS = 16;
    localparam int CODE_BITS = 12;
    localparam int NUM_CH = 4;
    localparam logic [4:0] LAST_BIT = 5'h0F;
    // Field positions in a link word
    localparam int LOAD_HI_POS = 15;
    localparam int LOAD_LO_POS = 14;
    localparam int PICK_HI_POS = 13;
    localparam int PICK_LO_POS = 12;
    localparam int ALL_CH_POS = 11;
    localparam int PD_CH_HI_POS = 10;
    localparam int PD_CH_LO_POS = 9;
    localparam int PD_TERM_HI_POS = 8;
    localparam int PD_TERM_LO_POS = 7;
    // Termination codes shown at the outputs
    localparam logic [1:0] TERM_HIZ = 2'h0;
    localparam logic [1:0] TERM_1K = 2'h1;
    localparam logic [1:0] TERM_100K = 2'h2;
    // APB byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_LAST = 8'h08;
    localparam logic [7:0] OFS_SOFT = 8'h0C;
    localparam logic [7:0] OFS_PWR = 8'h10;
    localparam logic [7:0] OFS_INP0 = 8'h20;
    localparam logic [7:0] OFS_DAC0 = 8'h30;
    // Reset values
    localparam logic CTRL_EN_RST = 1'b1;
    localparam logic [CODE_BITS-1:0] CODE_RST = 12'h000;
    // Receiver states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SHIFT = 2'b01,
        ST_DONE = 2'b10
    } qdsul_state_t;
    // Two select bits to a one-hot channel mask
    function automatic logic [3:0] chan_onehot(input logic [1:0] pick);
        chan_onehot = 4'h1 << pick;
    endfunction
endpackage

// ===== qdsul_sync2.sv
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/1ns
module qdsul_sync2 import qdsul_pkg::*; #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic [W-1:0] i_d,
    output logic [W-1:0] o_q
);
    typedef struct packed {
        logic [W-1:0] meta; // First stage, read only by second
        logic [W-1:0] stab; // Second stage
    } qdsul_sync_t;
    qdsul_sync_t s_q, s_d;

    // Shift the pins through both stages
    always_comb begin
        s_d.meta = i_d;
        s_d.stab = s_q.meta;
    end

    // Register the stages
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            s_q <= {RST_VAL, RST_VAL};
        end else begin
            s_q <= s_d;
        end
    end

    assign o_q = s_q.stab;
endmodule // qdsul_sync2

// ===== qdsul_decode.sv
// Command decoder for one received or software word
`timescale 1ns/1ns
module qdsul_decode import qdsul_pkg::*; (
    input wire logic [WORD_BITS-1:0] i_word,
    output logic [3:0] o_wr_inp,
    output logic [3:0] o_wr_dac,
    output logic [3:0] o_cp_dac,
    output logic [3:0] o_pd_set,
    output logic [1:0] o_term
);
    logic [1:0] load; // Load control bits
    logic [1:0] pick; // Channel pick bits
    logic [1:0] term_raw; // Termination field

    // Steer the word into register write masks
    always_comb begin
        load = {i_word[LOAD_HI_POS], i_word[LOAD_LO_POS]};
        pick = {i_word[PICK_HI_POS], i_word[PICK_LO_POS]};
        term_raw = {i_word[PD_TERM_HI_POS], i_word[PD_TERM_LO_POS]};
        o_wr_inp = 4'h0;
        o_wr_dac = 4'h0;
        o_cp_dac = 4'h0;
        o_pd_set = 4'h0;
        o_term = (term_raw == 2'h3) ? TERM_HIZ : term_raw;
        unique case (load)
            2'b00: begin
                o_wr_inp = chan_onehot(pick);
            end
            2'b01: begin
                o_cp_dac = chan_onehot(pick);
            end
            2'b10: begin
                o_wr_inp = chan_onehot(pick);
                o_wr_dac = chan_onehot(pick);
            end
            2'b11: begin
                unique case (pick)
                    2'b00: begin
                        o_wr_inp = 4'hF;
                        o_wr_dac = 4'hF;
                    end
                    2'b01: begin
                        o_cp_dac = 4'hF;
                    end
                    2'b10: begin
                        o_wr_inp = 4'hF;
                    end
                    2'b11: begin
                        o_pd_set = i_word[ALL_CH_POS] ? 4'hF :
                            chan_onehot({i_word[PD_CH_HI_POS],
                                         i_word[PD_CH_LO_POS]});
                    end
                endcase
            end
        endcase
    end
endmodule // qdsul_decode

// ===== qdsul_host_model.sv
// Host controller model that drives the three-wire link
`timescale 1ns/1ns
module qdsul_host_model import qdsul_pkg::*; (
    input wire logic i_clk,
    output logic o_sync_b,
    output logic o_sclk,
    output logic o_sdin
);
    // Idle link: select high, clock parked low
    initial begin
        o_sync_b = 1'b1;
        o_sclk = 1'b0;
        o_sdin = 1'b0;
    end

    // One frame: nbits clocked bits, then nextra surplus pulses
    // Serial clock is 8 system cycles, 800 ns, far below the limit
    task automatic send(input logic [15:0] w, input int nbits,
                        input int nextra);
        int i;
        @(posedge i_clk);
        o_sync_b <= 1'b0;
        repeat (4) @(posedge i_clk);
        // Data set with the rising edge, held past the fall
        for (i = 0; i < nbits + nextra; i++) begin
            // First 16 bits MSB first, surplus bits inverted junk
            o_sdin <= (i < 16) ? w[15-i] : ~w[i-16];
            o_sclk <= 1'b1;
            repeat (4) @(posedge i_clk);
            o_sclk <= 1'b0;
            repeat (4) @(posedge i_clk);
        end
        // Release only after the last fall; data line flips
        o_sync_b <= 1'b1;
        o_sdin <= ~o_sdin;
        repeat (8) @(posedge i_clk);
    endtask
endmodule // qdsul_host_model

// ===== test_quad_dac_serial_update_logic.sv
// Self-checking bench for the quad DAC serial update logic
`timescale 1ns/1ns
module test_quad_dac_serial_update_logic import qdsul_pkg::*;;
    logic i_clk = 1'b0; // System clock
    logic i_rst_b = 1'b0; // Reset, active low
    logic i_psel = 1'b0; // APB select
    logic i_penable = 1'b0; // APB enable
    logic i_pwrite = 1'b0; // APB direction
    logic [7:0] i_paddr = 8'h00; // APB address
    logic [31:0] i_pwdata = 32'h0000_0000; // APB write data
    logic [31:0] o_prdata; // APB read data
    logic o_pready; // APB ready
    logic o_pslverr; // APB error
    logic sync_b; // Link frame select
    logic sclk; // Link clock
    logic sdin; // Link data
    logic [CODE_BITS-1:0] code_w [4]; // Channel DAC codes
    logic [3:0] o_pwr_dn; // Power-down flags
    logic [7:0] o_term_sel; // Terminations
    logic [CODE_BITS-1:0] inp [4]; // Expected input registers
    logic [CODE_BITS-1:0] dac [4]; // Expected DAC registers
    logic [3:0] pd = 4'h0; // Expected power-down flags
    logic [1:0] term [4]; // Expected terminations
    logic [31:0] rd; // Last read data
    logic er; // Last error flag
    int err_count = 0; // Mismatches
    int n_tests = 0; // Comparisons

    // Clock, 100 ns period
    always #50 i_clk = ~i_clk;

    qdsul_top i_qdsul_top (.i_clk(i_clk), .i_rst_b(i_rst_b),
        .i_sync_b(sync_b), .i_sclk(sclk), .i_sdin(sdin),
        .i_paddr(i_paddr), .i_psel(i_psel), .i_penable(i_penable),
        .i_pwrite(i_pwrite), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
        .o_pready(o_pready), .o_pslverr(o_pslverr),
        .o_code_a(code_w[0]), .o_code_b(code_w[1]),
        .o_code_c(code_w[2]), .o_code_d(code_w[3]),
        .o_pwr_dn(o_pwr_dn), .o_term_sel(o_term_sel));

    qdsul_host_model i_qdsul_host_model (.i_clk(i_clk),
        .o_sync_b(sync_b), .o_sclk(sclk), .o_sdin(sdin));

    // Verdict and end of run
    task automatic results();
        $display("Comparisons %0d, mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // One comparison
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One APB transfer, entered just after a rising edge
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd);
        int n;
        n = 0;
        i_psel <= 1'b1;
        i_penable <= 1'b0;
        i_paddr <= a;
        i_pwrite <= wr;
        i_pwdata <= wd;
        @(posedge i_clk);
        i_penable <= 1'b1;
        // Access phase until ready, bounded
        do begin
            @(posedge i_clk);
            n++;
        end while (o_pready !== 1'b1 && n < 16);
        if (n >= 16) begin
            err_count++;
            $display("ERROR %0t: bus wait ran out", $time);
            results();
        end
        rd = o_prdata;
        er = o_pslverr;
        i_psel <= 1'b0;
        i_penable <= 1'b0;
        @(posedge i_clk);
    endtask

    // Update expected state for one complete word
    task automatic model(input logic [15:0] w);
        logic [1:0] op;
        logic [3:0] m;
        op = w[15:14];
        m = 4'h1 << w[13:12];
        // Load 11: select bits choose the broadcast operation
        if (w[15:14] == 2'b11) begin
            m = 4'hF;
            case (w[13:12])
                2'b00: op = 2'h2;
                2'b01: op = 2'h1;
                2'b10: op = 2'h0;
                default: begin
                    op = 2'h3;
                    m = w[11] ? 4'hF : 4'h1 << w[10:9];
                end
            endcase
        end
        for (int i = 0; i < 4; i++) begin
            if (m[i]) begin
                case (op)
                    2'h0: inp[i] = w[11:0];
                    2'h1: begin
                        dac[i] = inp[i];
                        pd[i] = 1'b0;
                    end
                    2'h2: begin
                        inp[i] = w[11:0];
                        dac[i] = w[11:0];
                        pd[i] = 1'b0;
                    end
                    default: begin
                        pd[i] = 1'b1;
                        term[i] = (w[8:7] == 2'h3) ? TERM_HIZ : w[8:7];
                    end
                endcase
            end
        end
    endtask

    // Compare codes, power-down flags, terminations of powered-down channels and input registers
    task automatic check_all();
        for (int i = 0; i < 4; i++) begin
            chk({20'h0, code_w[i]}, {20'h0, dac[i]});
            apb(1'b0, OFS_INP0 + 8'(4 * i), 32'h0);
            chk(rd, {20'h0, inp[i]});
            apb(1'b0, OFS_DAC0 + 8'(4 * i), 32'h0);
            chk(rd, {20'h0, dac[i]});
            chk({31'h0, o_pwr_dn[i]}, {31'h0, pd[i]});
            if (pd[i]) begin
                chk({30'h0, o_term_sel[2*i+:2]}, {30'h0, term[i]});
            end
        end
    endtask

    // Send a frame, track expectation when complete, check
    task automatic xfer(input logic [15:0] w, input int nb, input int nx);
        i_qdsul_host_model.send(w, nb, nx);
        if (nb == 16) begin
            model(w);
            apb(1'b0, OFS_LAST, 32'h0);
            chk(rd, {16'h0, w});
        end
        check_all();
    endtask

    // Main sequence
    initial begin
        for (int i = 0; i < 4; i++) begin
            inp[i] = 12'h000;
            dac[i] = 12'h000;
            term[i] = 2'h0;
        end
        repeat (12) @(posedge i_clk);
        i_rst_b <= 1'b1;
        repeat (10) @(posedge i_clk);
        check_all();
        apb(1'b0, OFS_CTRL, 32'h0);
        chk(rd, {31'h0, CTRL_EN_RST});
        // Unmapped address answers with error and zero
        apb(1'b0, 8'h44, 32'h0);
        chk({31'h0, er}, 32'h1);
        chk(rd, 32'h0);
        xfer(16'h1ABC, 16, 0);
        xfer(16'h5000, 16, 0);
        // Each channel written, codes from full scale to zero
        for (int i = 0; i < 4; i++) begin
            xfer({2'b10, 2'(i), 12'hFFF >> (4 * i)}, 16, 0);
        end
        xfer(16'hC5A5, 16, 0);
        xfer(16'hE123, 16, 0);
        xfer(16'hD000, 16, 0);
        xfer(16'h0777, 10, 0);
        xfer(16'h2456, 16, 6);
        // Single-channel power-down with every termination code
        for (int t = 0; t < 4; t++) begin
            xfer({4'hF, 1'b0, 2'(t), 2'(t), 7'h00}, 16, 0);
        end
        xfer(16'hF900, 16, 0);
        xfer(16'h2321, 16, 0);
        apb(1'b0, OFS_PWR, 32'h0);
        chk(rd, {20'h0, term[3], term[2], term[1], term[0], pd});
        // Link disabled: frame must leave everything alone
        apb(1'b1, OFS_CTRL, 32'h0);
        i_qdsul_host_model.send(16'h2FFF, 16, 0);
        check_all();
        apb(1'b1, OFS_CTRL, 32'h1);
        // Software word applies like a received one
        apb(1'b1, OFS_SOFT, 32'h0000_A7E5);
        model(16'hA7E5);
        repeat (2) @(posedge i_clk);
        check_all();
        apb(1'b0, OFS_SOFT, 32'h0);
        chk(rd, 32'h0000_A7E5);
        // Sixteen good frames, one aborted, receiver idle
        apb(1'b0, OFS_STATUS, 32'h0);
        chk(rd, 32'h0001_1000);
        results();
    end
endmodule // test_quad_dac_serial_update_logic
